/* File: logic/charge_seq_pkg.sv */
// shared constants, state encoding and carrier structs for the charge sequencer
package charge_seq_pkg;

    // clock rate and counter sizing
    localparam int CLK_KHZ = 50000;
    localparam int CNT_W = 28;

    // safety times as printed, in milliseconds
    localparam int EF_PERSIST_MS = 200;
    localparam int EF_DISC_MS = 5000;
    localparam int LOCK_CUT_MS = 2000;
    localparam int PILOT_CUT_MS = 30;
    localparam int OV_CUT_MS = 3000;

    // measurement units: current in 100 mA steps, voltage in 1 V steps
    localparam logic [15:0] CUR_5A = 16'h0032;
    localparam logic [15:0] VOLT_10 = 16'h000a;
    localparam logic [15:0] VOLT_20 = 16'h0014;
    localparam logic [15:0] VOLT_60 = 16'h003c;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] VMAX_OFS = 8'h04;
    localparam logic [7:0] IREQ_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] CMD_OFS = 8'h10;

    // control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_PARAMS = 2;
    localparam int CTRL_LOCK_SENT = 3;
    localparam int CTRL_SD_SENT = 4;
    localparam int CTRL_WELD_DONE = 5;
    localparam int CTRL_CLEAR = 6;

    // status register fields
    localparam int ST_STATE = 0;
    localparam int ST_D1 = 4;
    localparam int ST_D2 = 5;
    localparam int ST_UNLOCK = 6;
    localparam int ST_ENERGIZE = 7;
    localparam int ST_LOCK_REQ = 8;
    localparam int ST_SD_REQ = 9;
    localparam int ST_FLAGS = 10;
    localparam int ST_MISS = 14;

    // fault flag positions
    localparam int F_EARTH = 0;
    localparam int F_LOCK = 1;
    localparam int F_PILOT = 2;
    localparam int F_OV = 3;

    // reset values
    localparam logic [15:0] VMAX_RST = 16'h0000;
    localparam logic [15:0] IREQ_RST = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START = 4'b0001,
        ST_LOCK_RPT = 4'b0010,
        ST_PRECHECK = 4'b0011,
        ST_INSUL = 4'b0100,
        ST_POSTCHECK = 4'b0101,
        ST_TRANSFER = 4'b0110,
        ST_SD_ANNOUNCE = 4'b0111,
        ST_SD_RAMP = 4'b1000,
        ST_SD_WELD = 4'b1001,
        ST_SD_OPEN = 4'b1010,
        ST_SD_VCHECK = 4'b1011,
        ST_FAULT = 4'b1100
    } seq_state_e;

    // pin levels from the connector, asynchronous to pclk
    typedef struct packed {
        logic leak_over;
        logic lock_fail;
        logic start_stop_pilot;
        logic second_start_stop_pilot;
        logic charge_permission_pilot;
        logic vehicle_contactor_open;
    } pilot_pins_s;

    // measurement words, produced on pclk by the converter front end
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] cur;
        logic insul_done;
    } meas_s;

endpackage

/* File: logic/dc_charge_safety_sequencer.sv */
// station-side charge sequencer with safety reactions and apb registers
// Operation
// - earth fault: command current below 5 A
// - then open first pilot switch
// - earth fault: below 60 V within 5 s
// - earth fault detected within 1 s
// - declare earth fault only after 0.2 s persistence
// - unlock only with line voltage below 10 V
// - lock failure keeps DC lines de-energized
// - lock failure: below 5 A in 2 s, open
// - no pilot switch opens above 5 A
// - pilot loss: 5 A or less within 30 ms
// - overvoltage: below 5 A within 3 s
// - station pilots out, vehicle permission pilot in
// - start closes first switch, second stays open
// - insulation test waits for permission and parameters
// - report connector locked before insulation test
// - pre-test: contactors open, below 10 V
// - post-test below 20 V, then close second
// - earth fault monitor active during insulation test
// - transfer follows vehicle requested current
// - shutdown: announce, then reduce to 5 A
// - normal shutdown: switches closed until weld check
// - after switches open, below 10 V before unlock
module dc_charge_safety_sequencer
    import charge_seq_pkg::*;
#(
    parameter logic [CNT_W-1:0] EF_PERSIST_CYC = CNT_W'(EF_PERSIST_MS * CLK_KHZ + 1),
    parameter logic [CNT_W-1:0] EF_DISC_CYC = CNT_W'(EF_DISC_MS * CLK_KHZ),
    parameter logic [CNT_W-1:0] LOCK_CUT_CYC = CNT_W'(LOCK_CUT_MS * CLK_KHZ),
    parameter logic [CNT_W-1:0] PILOT_CUT_CYC = CNT_W'(PILOT_CUT_MS * CLK_KHZ),
    parameter logic [CNT_W-1:0] OV_CUT_CYC = CNT_W'(OV_CUT_MS * CLK_KHZ)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pilot_pins_s pins,
    input wire meas_s meas,
    output logic first_pilot_switch,
    output logic second_pilot_switch,
    output logic lock_release,
    output logic output_energize,
    output logic insul_test_enable,
    output logic [15:0] current_command
);

    typedef struct packed {
        seq_state_e st;
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [CNT_W-1:0] ef_cnt;
        logic [CNT_W-1:0] dl_cnt;
        logic dl_run;
        logic [3:0] flags;
        logic miss;
        logic d1;
        logic d2;
        logic unlock;
        logic energize;
        logic insul;
        logic [15:0] cur_cmd;
        logic [3:0] ctrl_lvl;
        logic start_p;
        logic stop_p;
        logic clear_p;
        logic [15:0] vmax;
        logic [15:0] ireq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } regs_s;

    localparam regs_s REGS_RST = '{
        st: ST_IDLE,
        sync1: 6'h00,
        sync2: 6'h00,
        ef_cnt: '0,
        dl_cnt: '0,
        dl_run: 1'b0,
        flags: 4'h0,
        miss: 1'b0,
        d1: 1'b0,
        d2: 1'b0,
        unlock: 1'b1,
        energize: 1'b0,
        insul: 1'b0,
        cur_cmd: 16'h0000,
        ctrl_lvl: 4'h0,
        start_p: 1'b0,
        stop_p: 1'b0,
        clear_p: 1'b0,
        vmax: VMAX_RST,
        ireq: IREQ_RST,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000
    };

    regs_s r;
    regs_s next_r;

    pilot_pins_s pin_s;
    logic cur_ok;
    logic active;
    logic charging;
    logic [3:0] fault_event;
    logic [3:0] new_flags;
    logic [CNT_W-1:0] cand;
    logic cand_valid;
    logic d1_open_req;
    logic d2_open_req;
    logic apb_access;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // combinational helpers

    always_comb begin
        pin_s = pilot_pins_s'(r.sync2);
        cur_ok = (meas.cur <= CUR_5A);
        active = (r.st != ST_IDLE);
        // current may still flow while the shutdown is being announced
        charging = (r.st == ST_TRANSFER) || (r.st == ST_SD_ANNOUNCE);
        apb_access = psel && penable && !r.pready;
        status_word = 32'h0000_0000;
        status_word[ST_STATE +: 4] = r.st;
        status_word[ST_D1] = r.d1;
        status_word[ST_D2] = r.d2;
        status_word[ST_UNLOCK] = r.unlock;
        status_word[ST_ENERGIZE] = r.energize;
        status_word[ST_LOCK_REQ] = (r.st == ST_LOCK_RPT);
        status_word[ST_SD_REQ] = (r.st == ST_SD_ANNOUNCE);
        status_word[ST_FLAGS +: 4] = r.flags;
        status_word[ST_MISS] = r.miss;
        // fault events; earth fault watched in every active state incl. test
        fault_event = 4'h0;
        fault_event[F_EARTH] = active && (r.ef_cnt >= EF_PERSIST_CYC);
        fault_event[F_LOCK] = charging && pin_s.lock_fail;
        fault_event[F_PILOT] = (r.st == ST_INSUL || charging)
            && (!pin_s.start_stop_pilot || (r.d2 && !pin_s.second_start_stop_pilot));
        fault_event[F_OV] = charging && (meas.volt > r.vmax);
        new_flags = fault_event & ~r.flags;
        // shortest deadline among the faults raised this cycle
        cand = '1;
        cand_valid = 1'b0;
        if (new_flags[F_PILOT]) begin
            cand = PILOT_CUT_CYC;
            cand_valid = 1'b1;
        end else if (new_flags[F_LOCK]) begin
            cand = LOCK_CUT_CYC;
            cand_valid = 1'b1;
        end else if (new_flags[F_OV]) begin
            cand = OV_CUT_CYC;
            cand_valid = 1'b1;
        end else if (new_flags[F_EARTH]) begin
            cand = EF_DISC_CYC;
            cand_valid = 1'b1;
        end
        d1_open_req = (r.st == ST_IDLE) || (r.st == ST_FAULT) || (r.st == ST_SD_OPEN)
            || (r.st == ST_SD_VCHECK);
        d2_open_req = d1_open_req || (r.st == ST_START) || (r.st == ST_LOCK_RPT)
            || (r.st == ST_PRECHECK) || (r.st == ST_INSUL) || (r.st == ST_POSTCHECK);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_r = r;
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;
        next_r.start_p = 1'b0;
        next_r.stop_p = 1'b0;
        next_r.clear_p = 1'b0;

        // apb slave, one wait state per access
        next_r.pready = apb_access;
        next_r.pslverr = 1'b0;
        next_r.prdata = 32'h0000_0000;
        if (psel && penable) begin
            case (paddr)
                CTRL_OFS: begin
                    next_r.prdata = {28'h0000000, r.ctrl_lvl} << CTRL_PARAMS;
                    if (pwrite && r.pready) begin
                        next_r.start_p = pwdata[CTRL_START];
                        next_r.stop_p = pwdata[CTRL_STOP];
                        next_r.clear_p = pwdata[CTRL_CLEAR];
                        next_r.ctrl_lvl = pwdata[CTRL_PARAMS +: 4];
                    end
                end
                VMAX_OFS: begin
                    next_r.prdata = {16'h0000, r.vmax};
                    if (pwrite && r.pready) begin
                        next_r.vmax = pwdata[15:0];
                    end
                end
                IREQ_OFS: begin
                    next_r.prdata = {16'h0000, r.ireq};
                    if (pwrite && r.pready) begin
                        next_r.ireq = pwdata[15:0];
                    end
                end
                STATUS_OFS: begin
                    next_r.prdata = status_word;
                end
                CMD_OFS: begin
                    next_r.prdata = {16'h0000, r.cur_cmd};
                end
                default: begin
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        if (!apb_access) begin
            next_r.prdata = 32'h0000_0000;
            next_r.pslverr = 1'b0;
        end

        // earth leakage persistence, continuous comparison
        if (pin_s.leak_over && active) begin
            if (r.ef_cnt < EF_PERSIST_CYC) begin
                next_r.ef_cnt = r.ef_cnt + 1'b1;
            end
        end else begin
            next_r.ef_cnt = '0;
        end

        // sticky fault flags: a new event beats a clear in the same cycle
        if (r.clear_p && r.st == ST_FAULT) begin
            next_r.flags = fault_event;
            next_r.miss = 1'b0;
        end else begin
            next_r.flags = r.flags | fault_event;
        end

        // one deadline counter; a tighter new deadline replaces a looser one
        if (cand_valid && (!r.dl_run || cand < r.dl_cnt)) begin
            next_r.dl_cnt = cand;
            next_r.dl_run = 1'b1;
        end else if (r.dl_run) begin
            if (cur_ok && (!r.flags[F_EARTH] || meas.volt < VOLT_60)) begin
                next_r.dl_run = 1'b0;
            end else if (r.dl_cnt <= 1) begin
                next_r.dl_run = 1'b0;
                next_r.miss = 1'b1;
            end else begin
                next_r.dl_cnt = r.dl_cnt - 1'b1;
            end
        end

        // sequencer
        next_r.insul = 1'b0;
        next_r.cur_cmd = 16'h0000;
        case (r.st)
            ST_IDLE: begin
                if (r.start_p && !pin_s.lock_fail) begin
                    next_r.st = ST_START;
                    next_r.unlock = 1'b0;
                end
            end
            ST_START: begin
                if (pin_s.charge_permission_pilot && r.ctrl_lvl[CTRL_PARAMS - CTRL_PARAMS]) begin
                    next_r.st = ST_LOCK_RPT;
                end
            end
            ST_LOCK_RPT: begin
                if (r.ctrl_lvl[CTRL_LOCK_SENT - CTRL_PARAMS]) begin
                    next_r.st = ST_PRECHECK;
                end
            end
            ST_PRECHECK: begin
                if (meas.volt > VOLT_10) begin
                    next_r.st = ST_SD_ANNOUNCE;
                end else if (meas.volt < VOLT_10 && pin_s.vehicle_contactor_open) begin
                    next_r.st = ST_INSUL;
                end
            end
            ST_INSUL: begin
                next_r.insul = 1'b1;
                if (meas.insul_done) begin
                    next_r.insul = 1'b0;
                    next_r.st = ST_POSTCHECK;
                end
            end
            ST_POSTCHECK: begin
                if (meas.volt < VOLT_20) begin
                    next_r.st = ST_TRANSFER;
                end
            end
            ST_TRANSFER: begin
                next_r.cur_cmd = r.ireq;
                if (!pin_s.charge_permission_pilot || r.stop_p) begin
                    next_r.st = ST_SD_ANNOUNCE;
                end
            end
            ST_SD_ANNOUNCE: begin
                next_r.cur_cmd = r.cur_cmd;
                if (r.ctrl_lvl[CTRL_SD_SENT - CTRL_PARAMS]) begin
                    next_r.st = ST_SD_RAMP;
                end
            end
            ST_SD_RAMP: begin
                if (cur_ok) begin
                    next_r.st = ST_SD_WELD;
                end
            end
            ST_SD_WELD: begin
                if (r.ctrl_lvl[CTRL_WELD_DONE - CTRL_PARAMS]) begin
                    next_r.st = ST_SD_OPEN;
                end
            end
            ST_SD_OPEN: begin
                if (!r.d1 && !r.d2) begin
                    next_r.st = ST_SD_VCHECK;
                end
            end
            ST_SD_VCHECK: begin
                if (meas.volt < VOLT_10) begin
                    next_r.unlock = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
            ST_FAULT: begin
                // current is already commanded to zero; switches follow below
                if (!r.d1 && !r.d2 && meas.volt < VOLT_10) begin
                    next_r.unlock = 1'b1;
                end
                if (r.clear_p && r.unlock && fault_event == 4'h0) begin
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_FAULT;
            end
        endcase

        // any fault overrides the sequence and drops the command at once
        if (fault_event != 4'h0 && r.st != ST_FAULT && r.st != ST_IDLE) begin
            next_r.st = ST_FAULT;
            next_r.cur_cmd = 16'h0000;
            next_r.insul = 1'b0;
        end

        // pilot switches: an opening waits until current is at or below 5 A
        if (d1_open_req) begin
            if (cur_ok) begin
                next_r.d1 = 1'b0;
            end
        end else begin
            next_r.d1 = 1'b1;
        end
        if (d2_open_req) begin
            if (cur_ok) begin
                next_r.d2 = 1'b0;
            end
        end else if (r.st == ST_TRANSFER) begin
            next_r.d2 = 1'b1;
        end

        // power path: never while a lock or latch failure is reported
        next_r.energize = !pin_s.lock_fail && (next_r.st == ST_INSUL
            || next_r.st == ST_POSTCHECK || next_r.st == ST_TRANSFER);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign first_pilot_switch = r.d1;
    assign second_pilot_switch = r.d2;
    assign lock_release = r.unlock;
    assign output_energize = r.energize;
    assign insul_test_enable = r.insul;
    assign current_command = r.cur_cmd;

endmodule

/* File: tb/seq_monitor.sv */
// port assertions for the charge sequencer
module seq_monitor
    import charge_seq_pkg::*;
#(
    parameter logic [CNT_W-1:0] EF_PERSIST_CYC = 20,
    parameter logic [CNT_W-1:0] OV_CUT_CYC = 150
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pilot_pins_s pins,
    input wire meas_s meas,
    input wire logic first_pilot_switch,
    input wire logic second_pilot_switch,
    input wire logic lock_release,
    input wire logic output_energize,
    input wire logic insul_test_enable,
    input wire logic [15:0] current_command
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] vmax;
    logic [7:0] leak_run;
    logic [CNT_W-1:0] ov_run;
    // vmax is shadowed from apb writes, so no hierarchical peek into the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vmax <= 16'h0000;
            leak_run <= 8'h00;
            ov_run <= '0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == VMAX_OFS) begin
                vmax <= pwdata[15:0];
            end
            leak_run <= pins.leak_over ? leak_run + 8'(leak_run != 8'hff) : 8'h00;
            ov_run <= (meas.volt > vmax && current_command > CUR_5A) ? ov_run + 1'b1 : '0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    a_open_first_low:
        assert property ($fell(first_pilot_switch) |-> $past(meas.cur) <= CUR_5A)
        else $error("first switch opened above 5 A");
    a_open_second_low:
        assert property ($fell(second_pilot_switch) |-> $past(meas.cur) <= CUR_5A)
        else $error("second switch opened above 5 A");
    a_test_second_open:
        assert property (insul_test_enable |-> !second_pilot_switch)
        else $error("second switch closed during test");
    a_second_after_test:
        assert property ($rose(second_pilot_switch) |-> first_pilot_switch && $past(meas.volt) < VOLT_20)
        else $error("second switch closed unsafely");
    a_unlock_low_volt:
        assert property ($rose(lock_release) |-> $past(meas.volt) < VOLT_10)
        else $error("unlock at high voltage");
    a_lock_no_energy:
        assert property (pins.lock_fail [*5] |-> !output_energize)
        else $error("energized with lock failure");
    a_lock_cut_cur:
        assert property (pins.lock_fail [*8] |-> current_command == 16'h0000)
        else $error("current kept with lock failure");
    a_pilot_cut_cur:
        assert property ($fell(pins.start_stop_pilot) && second_pilot_switch
            |-> ##[1:8] current_command <= CUR_5A)
        else $error("current kept after pilot loss");
    a_ov_cut_time:
        assert property (ov_run <= OV_CUT_CYC)
        else $error("overvoltage current not cut in time");
    a_earth_cut_cur:
        assert property (CNT_W'(leak_run) > EF_PERSIST_CYC + 6 |-> current_command == 16'h0000)
        else $error("current kept with earth fault");
    a_apb_unmapped:
        assert property (pready && paddr > CMD_OFS |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule

/* File: tb/vehicle_model.sv */
// behavioural vehicle side: pilot senses, measurements and test equipment
module vehicle_model
    import charge_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic permit,
    input wire logic leak,
    input wire logic lock_bad,
    input wire logic pilot_ok,
    input wire logic [15:0] volt,
    input wire logic first_pilot_switch,
    input wire logic second_pilot_switch,
    input wire logic [15:0] current_command,
    input wire logic insul_test_enable,
    output pilot_pins_s pins,
    output meas_s meas
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cur;
    logic [2:0] test_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= 16'h0000;
            test_cnt <= 3'b000;
        end else begin
            // slow mode ramps down 0.8 A a cycle, enough to miss a short deadline
            if (!slow || current_command >= cur || cur - current_command < 16'h0008) begin
                cur <= current_command;
            end else begin
                cur <= cur - 16'h0008;
            end
            test_cnt <= insul_test_enable ? {test_cnt[1:0], 1'b1} : 3'b000;
        end
    end
    always_comb begin
        pins.leak_over = leak;
        pins.lock_fail = lock_bad;
        pins.start_stop_pilot = pilot_ok;
        pins.second_start_stop_pilot = pilot_ok;
        pins.charge_permission_pilot = permit;
        pins.vehicle_contactor_open = !(first_pilot_switch && second_pilot_switch && permit);
        meas.volt = volt;
        meas.cur = cur;
        meas.insul_done = test_cnt[2];
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the charge sequencer
module testbench
    import charge_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [CNT_W-1:0] EFP = 20;
    localparam logic [CNT_W-1:0] OVC = 150;
    localparam logic [7:0] RA [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
    localparam logic [3:0] FL [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, lock_release, output_energize, insul_test_enable;
    logic first_pilot_switch, second_pilot_switch;
    logic [15:0] current_command, ireq;
    logic slow = 1'b0, permit = 1'b0, leak = 1'b0, lock_bad = 1'b0, pilot_ok = 1'b1;
    logic [15:0] volt = 16'h0000, seed = 16'h0042;
    pilot_pins_s pins;
    meas_s meas;
    int mismatches = 0, tests_run = 0;
    wire [1:0] sw = {first_pilot_switch, second_pilot_switch};
    always #10 pclk = ~pclk;
    dc_charge_safety_sequencer #(
        .EF_PERSIST_CYC(EFP), .EF_DISC_CYC(CNT_W'(200)), .LOCK_CUT_CYC(CNT_W'(100)),
        .PILOT_CUT_CYC(CNT_W'(30)), .OV_CUT_CYC(OVC)
    ) dc_charge_safety_sequencer_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pins, .meas, .first_pilot_switch, .second_pilot_switch, .lock_release,
        .output_energize, .insul_test_enable, .current_command
    );
    vehicle_model vehicle_model_i (
        .pclk, .presetn, .slow, .permit, .leak, .lock_bad, .pilot_ok, .volt,
        .first_pilot_switch, .second_pilot_switch, .current_command, .insul_test_enable,
        .pins, .meas
    );
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // request is held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_state(input logic [3:0] s);
        int n;
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, 32'h0);
            n++;
        end while (rd[3:0] !== s && n < 200);
        check(32'(rd[3:0]), 32'(s));
    endtask
    task automatic to_locked(input logic [15:0] cur, input logic [15:0] v);
        volt <= v;
        permit <= 1'b0;
        apb(1'b1, VMAX_OFS, 32'd400);
        apb(1'b1, IREQ_OFS, {16'h0, cur});
        apb(1'b1, CTRL_OFS, 32'h1);
        wait_state(4'd1);
        check(32'(sw), 32'h2);
        apb(1'b1, CTRL_OFS, 32'h4);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(32'(rd[3:0]), 32'h1);
        permit <= 1'b1;
        wait_state(4'd2);
        check(32'(rd[ST_LOCK_REQ]), 32'h1);
        apb(1'b1, CTRL_OFS, 32'hc);
    endtask
    task automatic shut_down(input logic [1:0] held);
        apb(1'b1, CTRL_OFS, 32'h1c);
        wait_state(4'd9);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(32'(sw), 32'(held));
        volt <= 16'd15;
        apb(1'b1, CTRL_OFS, 32'h3c);
        wait_state(4'd11);
        check(32'(sw), 32'h0);
        check(32'(lock_release), 32'h0);
        volt <= 16'd9;
        wait_state(4'd0);
        check(32'(lock_release), 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0);
    endtask
    initial begin
        int n;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check(32'({sw, lock_release}), 32'h1);
        apb(1'b1, STATUS_OFS, 32'hffffffff);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, RA[i], 32'h0);
            check(rd, (i == 3) ? 32'h40 : 32'h0);
            check(32'(er), 32'(i == 5));
        end
        seed = lfsr(seed);
        ireq = 16'h0040 + (seed & 16'h01bf);
        to_locked(ireq, 16'h0000);
        wait_state(4'd6);
        check(32'(sw), 32'h3);
        volt <= 16'd300;
        repeat (3) begin
            apb(1'b0, CMD_OFS, 32'h0);
            check(rd, {16'h0, ireq});
            seed = lfsr(seed);
            ireq = 16'h0040 + (seed & 16'h01bf);
            apb(1'b1, IREQ_OFS, {16'h0, ireq});
        end
        apb(1'b1, CTRL_OFS, 32'he);
        wait_state(4'd7);
        check(32'(rd[ST_SD_REQ]), 32'h1);
        check(32'(current_command), 32'(ireq));
        slow <= 1'b1;
        shut_down(2'b11);
        to_locked(16'h0100, 16'd20);
        wait_state(4'd7);
        shut_down(2'b10);
        // earth, lock, pilot, overvoltage, then lock and pilot together
        for (int k = 0; k < 5; k++) begin
            slow <= 1'b0;
            to_locked(16'h01ff, 16'h0000);
            wait_state(4'd6);
            volt <= 16'd300;
            leak <= (k == 0);
            repeat (10) @(posedge pclk);
            leak <= 1'b0;
            apb(1'b0, STATUS_OFS, 32'h0);
            check(32'(rd[3:0]), 32'h6);
            slow <= 1'b1;
            leak <= (k == 0);
            lock_bad <= (k == 1 || k == 4);
            pilot_ok <= !(k == 2 || k == 4);
            volt <= (k == 3) ? 16'd401 : 16'd300;
            wait_state(4'd12);
            check(32'(current_command), 32'h0);
            check(32'(rd[13:10]), 32'(FL[k]));
            if (k == 1) check(32'(output_energize), 32'h0);
            volt <= 16'h0000;
            n = 0;
            do begin
                apb(1'b0, STATUS_OFS, 32'h0);
                n++;
            end while (rd[ST_UNLOCK] !== 1'b1 && n < 200);
            check(32'(sw), 32'h0);
            check(32'(rd[ST_MISS]), 32'(k == 2 || k == 4));
            leak <= 1'b0;
            lock_bad <= 1'b0;
            pilot_ok <= 1'b1;
            apb(1'b1, CTRL_OFS, 32'h40);
            wait_state(4'd0);
            apb(1'b1, CTRL_OFS, 32'h0);
        end
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end
endmodule

bind dc_charge_safety_sequencer seq_monitor #(
    .EF_PERSIST_CYC(EF_PERSIST_CYC), .OV_CUT_CYC(OV_CUT_CYC)
) seq_monitor_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pins, .meas, .first_pilot_switch, .second_pilot_switch, .lock_release,
    .output_energize, .insul_test_enable, .current_command
);
